// ---- hw/tsc_capture.sv ----
// two-stop edge time capture unit with axi4-lite register access
// How it works
// - two stop inputs share one start; both edges captured, 32 hits each.
// - each stop uses a rising and a falling combined channel.
// - equal-polarity edges are captured whenever they are two clocks apart.
// - 8-bit falling-edge hit counter per stop, read in register 11.
// - 18-bit offsets from registers 5 and 6 added to each result.
// - an internal second start follows each accepted start.
// - inputs ignored until receiver power bit in register 6 is set.
// - per-input rising and falling enables in register 0; both off disables.
// - four block pins gate each stop and polarity.
// - inputs open after reset; optional start gating with 7 ns hold-off.
// - only the first start is used; optional start self-close.
// - retrigger bit makes every external start restart timing unless self-close is set.
// - raw hits go to 32-stage hit fifos.
// - collector moves hits to 256-entry interface fifos, 20 MHz per edge.
// - results on 28-bit bus; 0x0000010 to address 14 selects 16 bits.
// - low bus_output_enable keeps the result drivers permanently on.
// - each interface fifo drives high-active empty and level flags.
// - one fill threshold in register 6 sets both level flags.
// - quiet mode processes only on pin rising edge or software trigger.
// - non-quiet mode processes once a start and a stop are captured.
// - results valid at most 107 ns after processing starts.
// - first stop results at address 8, second at address 9.
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "tsc_cfg.svh"
module tsc_capture #(
  parameter int HIT_DEPTH = 32,
  parameter int HIT_AW    = 5,
  parameter int IF_DEPTH  = 256,
  parameter int IF_AW     = 8,
  parameter int TS_W      = 18,
  parameter int RES_W     = 22
) (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        ce_in,
  input  wire logic        start_in,
  input  wire logic [1:0]  diff_stop_input_in,
  input  wire logic [3:0]  stop_block_pin_in,
  input  wire logic        alu_trigger_in,
  input  wire logic        bus_output_enable_b_in,
  output logic      [27:0] result_data_out,
  output logic             result_oe_b_out,
  output logic      [1:0]  fifo_empty_flag_out,
  output logic      [1:0]  fifo_level_flag_out,
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  localparam int EW = RES_W + 1;

  // configuration registers
  logic [5:0]  edge_en_r;
  logic [7:0]  disable_r;
  logic [27:0] cfg5_r;
  logic [27:0] cfg6_r;
  logic        bus16_r;
  logic [7:0]  hit_count_r [2];
  logic        sw_trig_r;

  // bus slave
  tsc_pkg::tsc_bus_state_type wr_state_r;
  tsc_pkg::tsc_bus_state_type rd_state_r;
  logic        aw_got_r;
  logic        w_got_r;
  logic [3:0]  aw_idx_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        do_write;
  logic [31:0] wmask;
  logic [3:0]  ar_idx;
  logic        rd_take;
  logic [31:0] rd_word;
  logic        rd_ok;
  logic [1:0]  if_pop;

  // capture path
  logic [2:0]       ed_rise;
  logic [2:0]       ed_fall;
  logic [2:0]       ed_sig;
  logic [TS_W-1:0]  ts_r;
  logic [TS_W-1:0]  ref1_r;
  logic [TS_W-1:0]  ref2_r;
  logic             start_seen_r;
  logic             start_closed_r;
  logic             start2_done_r;
  logic [7:0]       start2_cnt_r;
  logic [3:0]       gate_cnt_r;
  logic             start_acc;
  logic             start_take;
  logic             stop_open;
  logic [3:0]       hit_p;
  logic [RES_W-1:0] hit_res;

  // post-processing
  tsc_pkg::tsc_pp_state_type pp_state_r;
  logic [3:0]    hit_empty;
  logic [EW-1:0] hit_data [4];
  logic [3:0]    hit_pop;
  logic [4:0]    xfer_cnt_r [4];
  logic [1:0]    if_push;
  logic [27:0]   if_din [2];
  logic [27:0]   if_dout [2];
  logic [1:0]    if_full;
  logic [IF_AW:0] if_count [2];
  logic          pp_go;
  logic          alu_prev_r;

  // ---------------- input edges ----------------
  assign ed_sig = {diff_stop_input_in, start_in};

  for (genvar i = 0; i < 3; i++) begin : g_edge
    tsc_edge u_edge (
      .clk_in     (clk_in),
      .rst_b_in   (rst_b_in),
      .ce_in      (ce_in),
      .sig_in     (ed_sig[i]),
      .rise_en_in (edge_en_r[i]),
      .fall_en_in (edge_en_r[i+3]),
      .rise_out   (ed_rise[i]),
      .fall_out   (ed_fall[i])
    );
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ts_r <= '0;
    end else if (ce_in) begin
      ts_r <= ts_r + 1'b1;
    end
  end

  // ---------------- start logic ----------------
  // receivers unpowered until the power bit is set
  assign start_acc = cfg6_r[`TSC_POWER_BIT] && (ed_rise[0] || ed_fall[0]);
  // later starts count only when retrigger is on
  assign start_take = start_acc && !start_closed_r &&
                      (!start_seen_r || cfg5_r[`TSC_RETRIG_BIT]);

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      start_seen_r   <= 1'b0;
      start_closed_r <= 1'b0;
      ref1_r         <= '0;
    end else if (ce_in && start_take) begin
      start_seen_r   <= 1'b1;
      start_closed_r <= cfg5_r[`TSC_CLOSE_BIT];
      ref1_r         <= ts_r;
    end
  end

  // internally generated second start after each accepted one
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      start2_cnt_r  <= '0;
      start2_done_r <= 1'b0;
      ref2_r        <= '0;
    end else if (ce_in) begin
      if (start_take) begin
        start2_cnt_r  <= 8'(`TSC_START2_CYC);
        start2_done_r <= 1'b0;
      end else if (start2_cnt_r == 8'h01) begin
        start2_cnt_r  <= '0;
        start2_done_r <= 1'b1;
        ref2_r        <= ts_r;
      end else if (start2_cnt_r != '0) begin
        start2_cnt_r <= start2_cnt_r - 1'b1;
      end
    end
  end

  // stop hold-off after the first start when gating is on
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      gate_cnt_r <= '0;
    end else if (ce_in) begin
      if (start_take && !start_seen_r) begin
        gate_cnt_r <= 4'(`TSC_GATE_CYC);
      end else if (gate_cnt_r != '0) begin
        gate_cnt_r <= gate_cnt_r - 1'b1;
      end
    end
  end

  assign stop_open = !cfg5_r[`TSC_WAIT_BIT] ||
                     (start_seen_r && gate_cnt_r == '0);

  // hits before the internal start refer to the external one
  assign hit_res = start2_done_r ?
    RES_W'(ts_r - ref2_r) + RES_W'(cfg6_r[`TSC_OFF_W-1:0]) :
    RES_W'(ts_r - ref1_r) + RES_W'(cfg5_r[`TSC_OFF_W-1:0]);

  // ---------------- combined channels ----------------
  // channel c: stop c/2, rising when c is even
  for (genvar c = 0; c < 4; c++) begin : g_hit
    logic edge_p;
    assign edge_p = (c % 2 == 0) ? ed_rise[c/2+1] : ed_fall[c/2+1];
    assign hit_p[c] = edge_p && cfg6_r[`TSC_POWER_BIT] && stop_open &&
                      !stop_block_pin_in[c] &&
                      !(disable_r[2*c] || disable_r[2*c+1]);

    tsc_fifo #(.W(EW), .DEPTH(HIT_DEPTH), .AW(HIT_AW)) u_hit (
      .clk_in    (clk_in),
      .rst_b_in  (rst_b_in),
      .ce_in     (ce_in),
      .push_in   (hit_p[c]),
      .data_in   ({1'(c % 2 == 0), hit_res}),
      .pop_in    (hit_pop[c]),
      .data_out  (hit_data[c]),
      .empty_out (hit_empty[c]),
      .full_out  (),
      .count_out ()
    );

    // per-edge rate limit, first slot held back by the pipeline latency
    always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
        xfer_cnt_r[c] <= 5'(`TSC_VALID_CYC - 1);
      end else if (ce_in) begin
        if (pp_state_r == tsc_pkg::TSC_PP_IDLE) begin
          xfer_cnt_r[c] <= 5'(`TSC_VALID_CYC - 1);
        end else if (hit_pop[c]) begin
          xfer_cnt_r[c] <= 5'(`TSC_XFER_CYC - 1);
        end else if (xfer_cnt_r[c] != '0) begin
          xfer_cnt_r[c] <= xfer_cnt_r[c] - 1'b1;
        end
      end
    end
  end

  // ---------------- post-processing control ----------------
  assign pp_go = cfg5_r[`TSC_QUIET_BIT] ?
                 (sw_trig_r || (alu_trigger_in && !alu_prev_r)) :
                 (start_seen_r && hit_empty != 4'hF);

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      alu_prev_r <= 1'b0;
    end else if (ce_in) begin
      alu_prev_r <= alu_trigger_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      pp_state_r <= tsc_pkg::TSC_PP_IDLE;
    end else if (ce_in) begin
      unique case (pp_state_r)
        tsc_pkg::TSC_PP_IDLE: begin
          if (pp_go) begin
            pp_state_r <= tsc_pkg::TSC_PP_RUN;
          end
        end
        tsc_pkg::TSC_PP_RUN: begin
          if (hit_empty == 4'hF) begin
            pp_state_r <= tsc_pkg::TSC_PP_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------- collector into interface fifos ----------------
  // rising channel wins a shared slot; falling waits one cycle
  for (genvar s = 0; s < 2; s++) begin : g_if
    logic rise_ok;
    logic fall_ok;
    assign rise_ok = pp_state_r == tsc_pkg::TSC_PP_RUN && !hit_empty[2*s] &&
                     xfer_cnt_r[2*s] == '0 && !if_full[s];
    assign fall_ok = pp_state_r == tsc_pkg::TSC_PP_RUN && !hit_empty[2*s+1] &&
                     xfer_cnt_r[2*s+1] == '0 && !if_full[s] && !rise_ok;
    assign hit_pop[2*s]   = ce_in && rise_ok;
    assign hit_pop[2*s+1] = ce_in && fall_ok;
    assign if_push[s]     = hit_pop[2*s] || hit_pop[2*s+1];
    assign if_din[s] = rise_ok ? 28'(hit_data[2*s]) : 28'(hit_data[2*s+1]);

    tsc_fifo #(.W(28), .DEPTH(IF_DEPTH), .AW(IF_AW)) u_if (
      .clk_in    (clk_in),
      .rst_b_in  (rst_b_in),
      .ce_in     (ce_in),
      .push_in   (if_push[s]),
      .data_in   (if_din[s]),
      .pop_in    (if_pop[s]),
      .data_out  (if_dout[s]),
      .empty_out (fifo_empty_flag_out[s]),
      .full_out  (if_full[s]),
      .count_out (if_count[s])
    );

    assign fifo_level_flag_out[s] =
      if_count[s] >= (IF_AW+1)'(cfg6_r[`TSC_FILL_LSB +: 9]);

    // stop hit counter on accepted falling edges
    always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
        hit_count_r[s] <= '0;
      end else if (ce_in && hit_p[2*s+1]) begin
        hit_count_r[s] <= hit_count_r[s] + 1'b1;
      end
    end
  end

  // ---------------- axi4-lite write ----------------
  assign s_axi_awready = wr_state_r == tsc_pkg::TSC_BUS_IDLE && !aw_got_r;
  assign s_axi_wready  = wr_state_r == tsc_pkg::TSC_BUS_IDLE && !w_got_r;
  assign s_axi_bvalid  = wr_state_r == tsc_pkg::TSC_BUS_RESP;
  assign do_write      = wr_state_r == tsc_pkg::TSC_BUS_IDLE && aw_got_r && w_got_r;

  for (genvar b = 0; b < 4; b++) begin : g_mask
    assign wmask[8*b +: 8] = {8{wstrb_r[b]}};
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      wr_state_r  <= tsc_pkg::TSC_BUS_IDLE;
      aw_got_r    <= 1'b0;
      w_got_r     <= 1'b0;
      aw_idx_r    <= '0;
      wdata_r     <= '0;
      wstrb_r     <= '0;
      s_axi_bresp <= `TSC_RESP_OKAY;
    end else if (ce_in) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_idx_r <= s_axi_awaddr[5:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      unique case (wr_state_r)
        tsc_pkg::TSC_BUS_IDLE: begin
          if (do_write) begin
            wr_state_r  <= tsc_pkg::TSC_BUS_RESP;
            aw_got_r    <= 1'b0;
            w_got_r     <= 1'b0;
            s_axi_bresp <= (aw_idx_r == `TSC_IDX_EDGE_EN || aw_idx_r == `TSC_IDX_DISABLE ||
                            aw_idx_r == `TSC_IDX_CFG5 || aw_idx_r == `TSC_IDX_CFG6 ||
                            aw_idx_r == `TSC_IDX_BUSW) ? `TSC_RESP_OKAY : `TSC_RESP_DECERR;
          end
        end
        tsc_pkg::TSC_BUS_RESP: begin
          if (s_axi_bready) begin
            wr_state_r <= tsc_pkg::TSC_BUS_IDLE;
          end
        end
      endcase
    end
  end

  // register writes; software trigger is a self-clearing pulse
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      edge_en_r <= `TSC_EDGE_EN_RST;
      disable_r <= '0;
      cfg5_r    <= '0;
      cfg6_r    <= {`TSC_FILL_RST, 19'h00000};
      bus16_r   <= 1'b0;
      sw_trig_r <= 1'b0;
    end else if (ce_in) begin
      sw_trig_r <= 1'b0;
      if (do_write) begin
        unique case (aw_idx_r)
          `TSC_IDX_EDGE_EN: edge_en_r <= 6'((wdata_r & wmask) | (32'(edge_en_r) & ~wmask));
          `TSC_IDX_DISABLE: disable_r <= 8'((wdata_r & wmask) | (32'(disable_r) & ~wmask));
          `TSC_IDX_CFG5: begin
            cfg5_r    <= 28'((wdata_r & wmask) | (32'(cfg5_r) & ~wmask));
            sw_trig_r <= wdata_r[`TSC_SWTRIG_BIT] && wstrb_r[2];
          end
          `TSC_IDX_CFG6: cfg6_r <= 28'((wdata_r & wmask) | (32'(cfg6_r) & ~wmask));
          `TSC_IDX_BUSW: bus16_r <= (wdata_r[27:0] == `TSC_BUS16_VAL);
          default: ;
        endcase
      end
    end
  end

  // ---------------- axi4-lite read ----------------
  assign ar_idx        = s_axi_araddr[5:2];
  assign s_axi_arready = rd_state_r == tsc_pkg::TSC_BUS_IDLE;
  assign s_axi_rvalid  = rd_state_r == tsc_pkg::TSC_BUS_RESP;
  assign rd_take       = ce_in && s_axi_arvalid && s_axi_arready;
  // an empty fifo read returns zero and pops nothing
  assign if_pop[0] = rd_take && ar_idx == `TSC_IDX_RES_A && !fifo_empty_flag_out[0];
  assign if_pop[1] = rd_take && ar_idx == `TSC_IDX_RES_B && !fifo_empty_flag_out[1];

  always_comb begin
    rd_word = '0;
    rd_ok   = 1'b1;
    unique case (ar_idx)
      `TSC_IDX_EDGE_EN: rd_word = 32'(edge_en_r);
      `TSC_IDX_DISABLE: rd_word = 32'(disable_r);
      `TSC_IDX_CFG5:    rd_word = 32'(cfg5_r & ~(28'h1 << `TSC_SWTRIG_BIT));
      `TSC_IDX_CFG6:    rd_word = 32'(cfg6_r);
      `TSC_IDX_RES_A:   rd_word = if_pop[0] ? 32'(if_dout[0]) : '0;
      `TSC_IDX_RES_B:   rd_word = if_pop[1] ? 32'(if_dout[1]) : '0;
      `TSC_IDX_COUNTS:  rd_word = {16'h0000, hit_count_r[1], hit_count_r[0]};
      `TSC_IDX_BUSW:    rd_word = bus16_r ? 32'(`TSC_BUS16_VAL) : '0;
      default:          rd_ok   = 1'b0;
    endcase
    if (bus16_r && (ar_idx == `TSC_IDX_RES_A || ar_idx == `TSC_IDX_RES_B)) begin
      rd_word = rd_word & 32'h0000FFFF;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rd_state_r      <= tsc_pkg::TSC_BUS_IDLE;
      s_axi_rdata     <= '0;
      s_axi_rresp     <= `TSC_RESP_OKAY;
      result_data_out <= '0;
    end else if (ce_in) begin
      unique case (rd_state_r)
        tsc_pkg::TSC_BUS_IDLE: begin
          if (rd_take) begin
            rd_state_r  <= tsc_pkg::TSC_BUS_RESP;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? `TSC_RESP_OKAY : `TSC_RESP_DECERR;
            if (if_pop != 2'b00) begin
              result_data_out <= rd_word[27:0];
            end
          end
        end
        tsc_pkg::TSC_BUS_RESP: begin
          if (s_axi_rready) begin
            rd_state_r <= tsc_pkg::TSC_BUS_IDLE;
          end
        end
      endcase
    end
  end

  // drivers stay on while the pin is low, else only during a read answer
  assign result_oe_b_out = bus_output_enable_b_in && !s_axi_rvalid;
endmodule : tsc_capture

// ---- hw/tsc_cfg.svh ----
// register map, field positions, reset values and timing constants
`ifndef TSC_CFG_SVH
`define TSC_CFG_SVH
`define TSC_CLK_PS      4000
`define TSC_IDX_EDGE_EN 4'h0
`define TSC_IDX_DISABLE 4'h2
`define TSC_IDX_CFG5    4'h5
`define TSC_IDX_CFG6    4'h6
`define TSC_IDX_RES_A   4'h8
`define TSC_IDX_RES_B   4'h9
`define TSC_IDX_COUNTS  4'hB
`define TSC_IDX_BUSW    4'hE
`define TSC_OFF_W       18
`define TSC_FILL_LSB    19
`define TSC_POWER_BIT   18
`define TSC_WAIT_BIT    18
`define TSC_CLOSE_BIT   19
`define TSC_RETRIG_BIT  20
`define TSC_QUIET_BIT   21
`define TSC_SWTRIG_BIT  22
`define TSC_EDGE_BIT    22
`define TSC_BUS16_VAL   28'h0000010
`define TSC_EDGE_EN_RST 6'h3F
`define TSC_FILL_RST    9'h010
`define TSC_GATE_PS     7000
`define TSC_VALID_PS    107000
`define TSC_XFER_PS     50000
`define TSC_START2_PS   40000
`define TSC_GATE_CYC    ((`TSC_GATE_PS + `TSC_CLK_PS - 1) / `TSC_CLK_PS)
`define TSC_VALID_CYC   (`TSC_VALID_PS / `TSC_CLK_PS)
`define TSC_XFER_CYC    ((`TSC_XFER_PS + `TSC_CLK_PS - 1) / `TSC_CLK_PS)
`define TSC_START2_CYC  ((`TSC_START2_PS + `TSC_CLK_PS - 1) / `TSC_CLK_PS)
`define TSC_RESP_OKAY   2'h0
`define TSC_RESP_DECERR 2'h3
`endif

// ---- hw/tsc_pkg.sv ----
// types shared by the time capture design
package tsc_pkg;
  typedef enum logic [1:0] {TSC_BUS_IDLE = 2'b01, TSC_BUS_RESP = 2'b10} tsc_bus_state_type;
  typedef enum logic [1:0] {TSC_PP_IDLE = 2'b01, TSC_PP_RUN = 2'b10} tsc_pp_state_type;
endpackage : tsc_pkg

// ---- hw/tsc_fifo.sv ----
// synchronous fifo with fill count, used for hit and interface buffers
`timescale 1ns/1ps
module tsc_fifo #(
  parameter int W     = 24,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic          clk_in,
  input  wire logic          rst_b_in,
  input  wire logic          ce_in,
  input  wire logic          push_in,
  input  wire logic [W-1:0]  data_in,
  input  wire logic          pop_in,
  output logic      [W-1:0]  data_out,
  output logic               empty_out,
  output logic               full_out,
  output logic      [AW:0]   count_out
);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   count_r;
  logic          do_push;
  logic          do_pop;

  // overflow and underflow are dropped rather than corrupting pointers
  assign do_push   = push_in && !full_out;
  assign do_pop    = pop_in && !empty_out;
  assign empty_out = (count_r == '0);
  assign full_out  = (count_r == (AW+1)'(DEPTH));
  assign count_out = count_r;
  assign data_out  = mem[rd_ptr_r];

  always_ff @(posedge clk_in) begin
    if (ce_in && do_push) begin
      mem[wr_ptr_r] <= data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (ce_in) begin
      if (do_push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule : tsc_fifo

// ---- hw/tsc_edge.sv ----
// edge detector with per-polarity sensitivity enables for one input
`timescale 1ns/1ps
module tsc_edge (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic ce_in,
  input  wire logic sig_in,
  input  wire logic rise_en_in,
  input  wire logic fall_en_in,
  output logic      rise_out,
  output logic      fall_out
);
  logic prev_r;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      prev_r <= 1'b0;
    end else if (ce_in) begin
      prev_r <= sig_in;
    end
  end

  // both enables low leaves the input dead
  assign rise_out = ce_in && rise_en_in && sig_in && !prev_r;
  assign fall_out = ce_in && fall_en_in && !sig_in && prev_r;
endmodule : tsc_edge

// ---- tb/tsc_capture_chk.sv ----
// port assertions for the capture unit
`timescale 1ns/1ps
`include "tsc_cfg.svh"
module tsc_capture_chk (
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  input wire logic        bus_output_enable_b_in,
  input wire logic        result_oe_b_out,
  input wire logic [27:0] result_data_out,
  input wire logic [1:0]  fifo_empty_flag_out,
  input wire logic [1:0]  fifo_level_flag_out,
  input wire logic [5:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid
);
  wire logic ar_acc = s_axi_arvalid && s_axi_arready;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  AST_OE_LOW:
  assert property ((!bus_output_enable_b_in || s_axi_rvalid) |-> !result_oe_b_out)
    else $error("bus drivers not enabled");
  AST_FLAGS_RST:
  assert property ($rose(rst_b_in) |-> fifo_empty_flag_out == 2'b11 && fifo_level_flag_out == 2'b00)
    else $error("flags wrong after reset");
  AST_LEVEL_EMPTY:
  assert property ((fifo_level_flag_out & fifo_empty_flag_out) == 2'b00)
    else $error("level flag set on empty fifo");
  AST_TOP_ZERO:
  assert property (s_axi_rvalid |-> s_axi_rdata[31:28] == 4'h0)
    else $error("read data above bit 27");
  AST_RES_OKAY:
  assert property (ar_acc && s_axi_araddr[5:3] == 3'h4 |=> s_axi_rvalid && s_axi_rresp == `TSC_RESP_OKAY)
    else $error("result read refused");
  AST_UNMAPPED:
  assert property (ar_acc && s_axi_araddr == 6'h3C |=> s_axi_rresp == `TSC_RESP_DECERR)
    else $error("unmapped read accepted");
  AST_ONE_READ:
  assert property (ar_acc |=> s_axi_rvalid && !s_axi_arready)
    else $error("second read taken early");
  AST_RES_HOLD:
  assert property ($changed(result_data_out) |-> $past(ar_acc) || $past(ar_acc, 2))
    else $error("result moved without read");
endmodule : tsc_capture_chk
bind tsc_capture tsc_capture_chk u_chk (.clk_in, .rst_b_in, .bus_output_enable_b_in,
  .result_oe_b_out, .result_data_out, .fifo_empty_flag_out, .fifo_level_flag_out,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid);

// ---- tb/tsc_host.sv ----
// host model: register bus master
`timescale 1ns/1ps
module tsc_host (
  input  wire logic        clk_in,
  output logic      [5:0]  s_axi_awaddr  = 6'h00,
  output logic             s_axi_awvalid = 1'b0,
  input  wire logic        s_axi_awready,
  output logic      [31:0] s_axi_wdata   = 32'h0,
  output logic      [3:0]  s_axi_wstrb   = 4'hF,
  output logic             s_axi_wvalid  = 1'b0,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready  = 1'b0,
  output logic      [5:0]  s_axi_araddr  = 6'h00,
  output logic             s_axi_arvalid = 1'b0,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready  = 1'b0
);
  // callers write disable bits in pairs only
  task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] resp);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
  endtask : wr
  // results read only while the empty flag is low, level flag unused
  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] resp);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clk_in); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_in); while (!s_axi_rvalid);
    d = s_axi_rdata;
    resp = s_axi_rresp;
  endtask : rd
endmodule : tsc_host

// ---- tb/tsc_capture_tb.sv ----
// self-checking bench for the capture unit
`timescale 1ns/1ps
`include "tsc_cfg.svh"
module tsc_capture_tb;
  logic        clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        start_in = 1'b0;
  logic [1:0]  diff_stop_input_in = 2'b00;
  logic [3:0]  stop_block_pin_in = 4'h0;
  logic        alu_trigger_in = 1'b0;
  logic        bus_output_enable_b_in = 1'b1;
  logic [27:0] result_data_out;
  logic        result_oe_b_out;
  logic [1:0]  fifo_empty_flag_out, fifo_level_flag_out, s_axi_bresp, s_axi_rresp, r;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          n_errors = 0;
  int          n_tests = 0;
  tsc_capture DUT (.clk_in, .rst_b_in, .ce_in(1'b1), .start_in, .diff_stop_input_in,
    .stop_block_pin_in, .alu_trigger_in, .bus_output_enable_b_in, .result_data_out,
    .result_oe_b_out, .fifo_empty_flag_out, .fifo_level_flag_out, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  tsc_host u_host (.clk_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  always #2 clk_in = ~clk_in;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic wc(input logic [5:0] a, input logic [31:0] v);
    u_host.wr(a, v, r);
    chk({30'h0, r}, `TSC_RESP_OKAY);
  endtask : wc
  task automatic rc(input logic [5:0] a, input logic [31:0] exp);
    u_host.rd(a, d, r);
    chk(d, exp);
    chk({30'h0, r}, `TSC_RESP_OKAY);
  endtask : rc
  task automatic eflags(input logic [1:0] e);
    #1;
    chk({30'h0, fifo_empty_flag_out}, {30'h0, e});
    @(posedge clk_in);
  endtask : eflags
  // stop edges 3 and 5 cycles after the start edge
  task automatic shoot(input logic [1:0] stops);
    start_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    diff_stop_input_in <= stops;
    repeat (2) @(posedge clk_in);
    diff_stop_input_in <= 2'b00;
    start_in <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask : shoot
  // bound of 30 cycles covers the 26-cycle first transfer
  task automatic wait_data(input int i);
    int n;
    n = 0;
    while (fifo_empty_flag_out[i] !== 1'b0 && n < 30) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk({31'h0, fifo_empty_flag_out[i]}, 32'h0);
    repeat (14) @(posedge clk_in);
  endtask : wait_data
  initial begin
    #80000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    eflags(2'b11);
    bus_output_enable_b_in <= 1'b0;
    #1;
    chk({31'h0, result_oe_b_out}, 32'h0);
    @(posedge clk_in);
    bus_output_enable_b_in <= 1'b1;
    rc(6'h00, 32'h3F);
    rc(6'h18, 32'h0080_0000);
    u_host.rd(6'h3C, d, r);
    chk({30'h0, r}, `TSC_RESP_DECERR);
    shoot(2'b11);
    repeat (40) @(posedge clk_in);
    eflags(2'b11);
    wc(6'h00, 32'h37);
    wc(6'h14, 32'h10);
    wc(6'h18, 32'h0014_0000);
    shoot(2'b01);
    wait_data(0);
    chk({30'h0, fifo_level_flag_out}, 32'h1);
    rc(6'h20, 32'h0040_0013);
    rc(6'h20, 32'h0000_0015);
    eflags(2'b11);
    wc(6'h08, 32'h0C);
    stop_block_pin_in <= 4'h8;
    shoot(2'b11);
    wait_data(1);
    u_host.rd(6'h20, d, r);
    chk({31'h0, d[22]}, 32'h1);
    u_host.rd(6'h24, d, r);
    chk({31'h0, d[22]}, 32'h1);
    eflags(2'b11);
    wc(6'h08, 32'h0);
    stop_block_pin_in <= 4'h0;
    wc(6'h14, 32'h0030_0010);
    shoot(2'b01);
    repeat (40) @(posedge clk_in);
    eflags(2'b11);
    alu_trigger_in <= 1'b1;
    @(posedge clk_in);
    alu_trigger_in <= 1'b0;
    wait_data(0);
    wc(6'h38, `TSC_BUS16_VAL);
    rc(6'h20, 32'h0000_0013);
    chk({4'h0, result_data_out}, 32'h13);
    rc(6'h20, 32'h0000_0015);
    rc(6'h2C, 32'h2);
    tally_and_finish();
  end
endmodule : tsc_capture_tb
